// [hw/scs_top.v]
// System clock source selection and oscillator control
//
// What this block does
// - Instruction clock is processor clock halved
// - Multiplier only on primary or fast RC
// - Fast RC may pass a programmable divider
// - Boot source from the initial source field alone
// - Erased settings start divided fast RC
// - External clock range field, default above 8MHz
// - Switching only when upper switch bit 0
// - Fail monitor only when both bits 0
// - Internal mode source code decoding
// - Primary codes with and without multiplier
// - Current source field read only, resets 0
// - Current and requested share one encoding
// - Requested field writable, loaded from boot
// - Lock status cleared on switch, non-multiplier
// - Drive bit ignored for digital input
// - Freeze bit set only by software
// - Fail flag cleared only by software
// - Secondary power variant from config bit
// - Out pin gives instruction clock or I/O
// - Fast RC tune setting in fixed steps
// - Switch bit starts switch, cleared when done
// - Freeze holds selections only with monitor
// - Lock reads 1 when locked or started
// - Monitor failure sets the fail flag
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "scs_defs.vh"
module scs_top (
  // Clock and reset
  input wire CLK_SYS,
  input wire NRST,
  // Register port
  input wire [3:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [15:0] REG_RDATA,
  // Configuration straps
  input wire [1:0] CFG_PRIMARY_MODE,
  input wire [2:0] CFG_INITIAL_SOURCE,
  input wire [1:0] CFG_EXT_CLOCK_RANGE,
  input wire [1:0] CFG_SWITCH_MONITOR,
  input wire CFG_SECONDARY_POWER_VARIANT,
  input wire CFG_SECONDARY_INPUT_TYPE,
  input wire CFG_OUT_PIN_FUNCTION,
  // Source clock ticks
  input wire FAST_RC_TICK,
  input wire SLOW_RC_TICK,
  input wire LOW_POWER_RC_TICK,
  input wire SECONDARY_OSC_TICK,
  input wire PRIMARY_OSC_TICK,
  input wire PLL_TICK,
  input wire PLL_LOCKED,
  // Oscillator controls
  output reg PLL_ENABLE,
  output reg PLL_FROM_PRIMARY,
  output reg SECONDARY_ENABLE,
  output reg SECONDARY_HIGH_POWER,
  output reg [5:0] FAST_RC_TUNE,
  output reg [1:0] EXT_CLOCK_RANGE,
  output reg [1:0] PRIMARY_MODE,
  output reg MONITOR_ENABLED,
  // Clock results
  output reg PROC_CLK_EN,
  output reg INSTR_CLK,
  output reg INSTR_CLK_EN,
  output reg [2:0] CURRENT_SOURCE,
  // Oscillator out pin
  output reg OSC_OUT_O,
  output reg OSC_OUT_OE
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function is_pll;
    input [2:0] code;
    begin
      is_pll = (code == `SCS_SRC_FRC_PLL) || (code == `SCS_SRC_PRI_PLL);
    end
  endfunction

  localparam ST_IDLE = 1'b0;
  localparam ST_SETTLE = 1'b1;
  localparam integer PLL_CYCLES = `SCS_PLL_CYCLES;
  localparam [8:0] PLL_LIMIT = PLL_CYCLES[8:0];
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg booted;
  reg [1:0] cfg_switch;
  reg cfg_variant;
  reg cfg_input_type;
  reg cfg_out_fn;
  reg [2:0] current_source_field;
  reg [2:0] requested_source_field;
  reg [2:0] target;
  reg selection_freeze_bit;
  reg lock_status;
  reg clock_fail_flag;
  reg secondary_drive_strength;
  reg secondary_enable;
  reg switch_request_bit;
  reg [2:0] divider_ratio;
  reg [5:0] fast_rc_tune;
  reg state;
  reg [2:0] settle_count;
  reg [8:0] pll_timer;
  reg instr_phase;

  wire frc_div_tick;
  wire slow_div_tick;
  wire monitor_fail;
  wire [7:0] src_vec;
  wire cur_tick;
  wire tgt_tick;
  wire switch_allowed;
  wire frozen;
  wire wr_ctrl;
  wire switch_start;
  wire switch_done;
  wire pin_free;

  // ----------------------------------------
  // Source dividers and tick selection
  // ----------------------------------------
  scs_tick_divider u_frc_div (
    .clk(CLK_SYS),
    .nrst(NRST),
    .tick_in(FAST_RC_TICK),
    .ratio(divider_ratio),
    .tick_out(frc_div_tick)
  );

  scs_tick_divider u_slow_div (
    .clk(CLK_SYS),
    .nrst(NRST),
    .tick_in(SLOW_RC_TICK),
    .ratio(divider_ratio),
    .tick_out(slow_div_tick)
  );

  // Multiplier only behind primary and fast RC codes
  assign src_vec = {frc_div_tick, slow_div_tick, LOW_POWER_RC_TICK, SECONDARY_OSC_TICK,
                    PLL_TICK, PRIMARY_OSC_TICK, PLL_TICK, FAST_RC_TICK};
  assign cur_tick = src_vec[current_source_field];
  assign tgt_tick = src_vec[target];

  // ----------------------------------------
  // Switch permission
  // ----------------------------------------
  assign switch_allowed = booted && !cfg_switch[1];
  assign frozen = selection_freeze_bit && (cfg_switch == 2'h0);
  assign wr_ctrl = REG_WR && (REG_ADDR == `SCS_OFF_OSC_CTRL);
  assign switch_start = (state == ST_IDLE) && switch_request_bit;
  assign switch_done = (state == ST_SETTLE) && tgt_tick && (settle_count == `SCS_SETTLE_TICKS - 3'h1);

  // ----------------------------------------
  // Fail monitor
  // ----------------------------------------
  scs_fail_monitor u_monitor (
    .clk(CLK_SYS),
    .nrst(NRST),
    .enable(booted && (cfg_switch == 2'h0)),
    .restart(switch_done),
    .tick(cur_tick),
    .fail(monitor_fail)
  );

  // ----------------------------------------
  // Boot capture of configuration
  // ----------------------------------------
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      booted <= 1'b0;
      cfg_switch <= 2'h3;
      cfg_variant <= 1'b0;
      cfg_input_type <= 1'b0;
      cfg_out_fn <= 1'b0;
      EXT_CLOCK_RANGE <= 2'h0;
      PRIMARY_MODE <= 2'h0;
      MONITOR_ENABLED <= 1'b0;
    end else if (!booted) begin
      booted <= 1'b1;
      cfg_switch <= CFG_SWITCH_MONITOR;
      cfg_variant <= CFG_SECONDARY_POWER_VARIANT;
      cfg_input_type <= CFG_SECONDARY_INPUT_TYPE;
      cfg_out_fn <= CFG_OUT_PIN_FUNCTION;
      EXT_CLOCK_RANGE <= CFG_EXT_CLOCK_RANGE;
      PRIMARY_MODE <= CFG_PRIMARY_MODE;
      MONITOR_ENABLED <= (CFG_SWITCH_MONITOR == 2'h0);
    end
  end

  // ----------------------------------------
  // Source fields and switch sequencer
  // ----------------------------------------
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      current_source_field <= `SCS_CUR_RESET;
      requested_source_field <= `SCS_CUR_RESET;
      target <= `SCS_CUR_RESET;
      switch_request_bit <= 1'b0;
      state <= ST_IDLE;
      settle_count <= 3'h0;
    end else if (!booted) begin
      // Erased straps give the divided fast RC code
      current_source_field <= CFG_INITIAL_SOURCE;
      requested_source_field <= CFG_INITIAL_SOURCE;
      target <= CFG_INITIAL_SOURCE;
    end else begin
      if (wr_ctrl && !frozen) begin
        requested_source_field <= REG_WDATA[`SCS_REQ_HI:`SCS_REQ_LO];
      end
      case (state)
        ST_IDLE: begin
          settle_count <= 3'h0;
          if (switch_start) begin
            target <= requested_source_field;
            state <= ST_SETTLE;
          end else if (wr_ctrl && REG_WDATA[`SCS_SWITCH_BIT] && switch_allowed && !frozen) begin
            switch_request_bit <= 1'b1;
          end
          if (monitor_fail) begin
            current_source_field <= `SCS_SRC_FRC;
          end
        end
        ST_SETTLE: begin
          if (tgt_tick) begin
            settle_count <= settle_count + 3'h1;
          end
          if (switch_done) begin
            current_source_field <= target;
            switch_request_bit <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Lock, freeze and fail flags
  // ----------------------------------------
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      selection_freeze_bit <= 1'b0;
      clock_fail_flag <= 1'b0;
      lock_status <= 1'b0;
      pll_timer <= 9'h000;
    end else begin
      if (wr_ctrl && REG_WDATA[`SCS_FREEZE_BIT]) begin
        selection_freeze_bit <= 1'b1;
      end
      if (monitor_fail) begin
        clock_fail_flag <= 1'b1;
      end else if (wr_ctrl && !REG_WDATA[`SCS_FAIL_BIT]) begin
        clock_fail_flag <= 1'b0;
      end
      if (switch_start || !is_pll(current_source_field)) begin
        lock_status <= 1'b0;
        pll_timer <= 9'h000;
      end else begin
        if (pll_timer != PLL_LIMIT) begin
          pll_timer <= pll_timer + 9'h001;
        end
        lock_status <= PLL_LOCKED || (pll_timer == PLL_LIMIT);
      end
    end
  end

  // ----------------------------------------
  // Plain control registers
  // ----------------------------------------
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      secondary_drive_strength <= 1'b0;
      secondary_enable <= 1'b0;
      divider_ratio <= `SCS_DIV_RESET;
      fast_rc_tune <= `SCS_TUNE_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == `SCS_OFF_OSC_CTRL) begin
        secondary_drive_strength <= REG_WDATA[`SCS_DRIVE_BIT];
        secondary_enable <= REG_WDATA[`SCS_SEC_EN_BIT];
      end
      if (REG_ADDR == `SCS_OFF_DIVIDER) begin
        divider_ratio <= REG_WDATA[`SCS_DIV_HI:0];
      end
      if (REG_ADDR == `SCS_OFF_TUNE) begin
        fast_rc_tune <= REG_WDATA[`SCS_TUNE_HI:0];
      end
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `SCS_OFF_OSC_CTRL: begin
          REG_RDATA <= {1'b0, current_source_field, 1'b0, requested_source_field,
                        selection_freeze_bit, 1'b0, lock_status, 1'b0, clock_fail_flag,
                        secondary_drive_strength, secondary_enable, switch_request_bit};
        end
        `SCS_OFF_DIVIDER: begin
          REG_RDATA <= {13'h0000, divider_ratio};
        end
        `SCS_OFF_TUNE: begin
          REG_RDATA <= {10'h000, fast_rc_tune};
        end
        default: begin
          REG_RDATA <= 16'h0000;
        end
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Clock outputs and oscillator controls
  // ----------------------------------------
  // Pin is free unless a crystal sits on it
  assign pin_free = (PRIMARY_MODE == `SCS_PMODE_EXT) || (PRIMARY_MODE == `SCS_PMODE_INTERNAL);

  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      instr_phase <= 1'b0;
      PROC_CLK_EN <= 1'b0;
      INSTR_CLK <= 1'b0;
      INSTR_CLK_EN <= 1'b0;
      CURRENT_SOURCE <= `SCS_CUR_RESET;
      PLL_ENABLE <= 1'b0;
      PLL_FROM_PRIMARY <= 1'b0;
      SECONDARY_ENABLE <= 1'b0;
      SECONDARY_HIGH_POWER <= 1'b0;
      FAST_RC_TUNE <= `SCS_TUNE_RESET;
      OSC_OUT_O <= 1'b0;
      OSC_OUT_OE <= 1'b0;
    end else begin
      PROC_CLK_EN <= cur_tick && (state == ST_IDLE);
      if (cur_tick && (state == ST_IDLE)) begin
        instr_phase <= ~instr_phase;
      end
      INSTR_CLK <= instr_phase;
      INSTR_CLK_EN <= cur_tick && (state == ST_IDLE) && instr_phase;
      CURRENT_SOURCE <= current_source_field;
      PLL_ENABLE <= booted && (is_pll(current_source_field) || is_pll(target));
      PLL_FROM_PRIMARY <= (state == ST_SETTLE) ? (target == `SCS_SRC_PRI_PLL)
                                               : (current_source_field == `SCS_SRC_PRI_PLL);
      SECONDARY_ENABLE <= secondary_enable || (current_source_field == `SCS_SRC_SEC)
                          || (target == `SCS_SRC_SEC);
      SECONDARY_HIGH_POWER <= cfg_variant || (cfg_input_type && secondary_drive_strength);
      FAST_RC_TUNE <= fast_rc_tune;
      OSC_OUT_O <= instr_phase;
      OSC_OUT_OE <= booted && pin_free && cfg_out_fn;
    end
  end

endmodule

// [hw/scs_defs.vh]
// Constants for the system clock source select block
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCS_ADDR_W 4
`define SCS_OFF_OSC_CTRL 4'h0
`define SCS_OFF_DIVIDER 4'h1
`define SCS_OFF_TUNE 4'h2

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SCS_CUR_HI 14
`define SCS_CUR_LO 12
`define SCS_REQ_HI 10
`define SCS_REQ_LO 8
`define SCS_FREEZE_BIT 7
`define SCS_LOCK_BIT 5
`define SCS_FAIL_BIT 3
`define SCS_DRIVE_BIT 2
`define SCS_SEC_EN_BIT 1
`define SCS_SWITCH_BIT 0
`define SCS_DIV_HI 2
`define SCS_TUNE_HI 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCS_CUR_RESET 3'h0
`define SCS_DIV_RESET 3'h1
`define SCS_TUNE_RESET 6'h00

// ----------------------------------------
// Source codes
// ----------------------------------------
`define SCS_SRC_FRC 3'h0
`define SCS_SRC_FRC_PLL 3'h1
`define SCS_SRC_PRI 3'h2
`define SCS_SRC_PRI_PLL 3'h3
`define SCS_SRC_SEC 3'h4
`define SCS_SRC_LOW_POWER_RC_SOURCE 3'h5
`define SCS_SRC_SLOW_DIV 3'h6
`define SCS_SRC_FRC_DIV 3'h7
`define SCS_PMODE_EXT 2'h0
`define SCS_PMODE_INTERNAL 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCS_CLK_PERIOD_NS 8
`define SCS_FAIL_TIMEOUT_NS 2000
`define SCS_FAIL_CYCLES ((`SCS_FAIL_TIMEOUT_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_PLL_START_NS 2000
`define SCS_PLL_CYCLES ((`SCS_PLL_START_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_SETTLE_TICKS 3'h4

`endif

// [hw/scs_tick_divider.v]
// Power-of-two divider for a one-cycle clock tick
`timescale 1ns/100ps
module scs_tick_divider (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Tick in and out
  input wire tick_in,
  input wire [2:0] ratio,
  output reg tick_out
);
  reg [6:0] count;
  wire [6:0] mask;
  assign mask = ~(7'h7f << ratio);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 7'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in & ((count & mask) == mask);
      if (tick_in) begin
        count <= count + 7'h01;
      end
    end
  end
endmodule

// [hw/scs_fail_monitor.v]
// Watchdog that flags a running clock that stops ticking
`timescale 1ns/100ps
`include "scs_defs.vh"
module scs_fail_monitor (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Watched clock
  input wire enable,
  input wire restart,
  input wire tick,
  output reg fail
);
  localparam integer LIMIT_CYCLES = `SCS_FAIL_CYCLES;
  localparam [8:0] LIMIT = LIMIT_CYCLES[8:0];
  reg [8:0] count;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 9'h000;
      fail <= 1'b0;
    end else begin
      fail <= 1'b0;
      if (!enable || restart || tick) begin
        count <= 9'h000;
      end else if (count == LIMIT - 9'h001) begin
        count <= 9'h000;
        fail <= 1'b1;
      end else begin
        count <= count + 9'h001;
      end
    end
  end
endmodule

// [testbench/scs_chk.sv]
// Checker for the clock source select top, bound to its ports
`timescale 1ns/100ps
module scs_chk (
  // Clock and reset
  input wire CLK_SYS,
  input wire NRST,
  // Register port
  input wire [3:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_RDATA,
  // Straps
  input wire [1:0] CFG_PRIMARY_MODE,
  input wire [2:0] CFG_INITIAL_SOURCE,
  input wire [1:0] CFG_SWITCH_MONITOR,
  input wire CFG_SECONDARY_POWER_VARIANT,
  input wire CFG_SECONDARY_INPUT_TYPE,
  input wire CFG_OUT_PIN_FUNCTION,
  // Results
  input wire PLL_ENABLE,
  input wire SECONDARY_HIGH_POWER,
  input wire MONITOR_ENABLED,
  input wire PROC_CLK_EN,
  input wire INSTR_CLK_EN,
  input wire INSTR_CLK,
  input wire [2:0] CURRENT_SOURCE,
  input wire OSC_OUT_O,
  input wire OSC_OUT_OE
);
  reg [1:0] rcnt;
  reg [1:0] pcnt;
  wire booted = rcnt == 2'h3;
  // Cycles since reset, processor ticks since last instruction tick
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rcnt <= 2'h0;
      pcnt <= 2'h0;
    end else begin
      rcnt <= rcnt + {1'b0, !booted};
      pcnt <= INSTR_CLK_EN ? 2'h0 : pcnt + {1'b0, PROC_CLK_EN && pcnt != 2'h3};
    end
  end
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  sequence s_ctrl_read;
    REG_RD && REG_ADDR == 4'h0;
  endsequence
  sequence s_sw_write;
    REG_WR && REG_ADDR == 4'h0 && REG_WDATA[0] && CFG_SWITCH_MONITOR[1];
  endsequence
  chk_boot_source: assert property (rcnt == 2'h2 |-> CURRENT_SOURCE == CFG_INITIAL_SOURCE)
    else $error("boot source not loaded");
  chk_unused_zero: assert property (s_ctrl_read |=> (REG_RDATA & 16'h8850) == 16'h0000)
    else $error("unused control bits not zero");
  chk_current_field: assert property (s_ctrl_read |=> REG_RDATA[14:12] == CURRENT_SOURCE)
    else $error("current field differs from current source");
  chk_instr_half: assert property (INSTR_CLK_EN |-> PROC_CLK_EN && pcnt == 2'h1)
    else $error("instruction tick not every second tick");
  chk_pll_on: assert property ((CURRENT_SOURCE == 3'h1 || CURRENT_SOURCE == 3'h3) [*2] |-> PLL_ENABLE)
    else $error("multiplier off in multiplied mode");
  chk_monitor_strap: assert property (booted |-> MONITOR_ENABLED == (CFG_SWITCH_MONITOR == 2'h0))
    else $error("monitor enable wrong");
  chk_switch_gate: assert property (booted && CFG_SWITCH_MONITOR[1] |-> $stable(CURRENT_SOURCE))
    else $error("source changed with switching off");
  chk_switch_ignored: assert property (s_sw_write ##[1:2] s_ctrl_read |=> !REG_RDATA[0])
    else $error("switch bit taken with switching off");
  chk_lock_nonpll: assert property (s_ctrl_read and !PLL_ENABLE |=> !REG_RDATA[5])
    else $error("lock set without multiplier");
  chk_sec_power: assert property (booted && !CFG_SECONDARY_INPUT_TYPE |-> SECONDARY_HIGH_POWER == CFG_SECONDARY_POWER_VARIANT)
    else $error("secondary power wrong");
  chk_out_pin: assert property (booted |-> OSC_OUT_OE == (CFG_OUT_PIN_FUNCTION && CFG_PRIMARY_MODE != 2'h1 && CFG_PRIMARY_MODE != 2'h2))
    else $error("out pin enable wrong");
  chk_switch_quiet: assert property (booted && $changed(CURRENT_SOURCE) |-> $past(PROC_CLK_EN) == 1'b0)
    else $error("processor ticks during switch");
  chk_instr_level: assert property (INSTR_CLK_EN |-> INSTR_CLK && (OSC_OUT_O || !OSC_OUT_OE))
    else $error("instruction clock level wrong");
endmodule
bind scs_top scs_chk u_chk (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CFG_PRIMARY_MODE(CFG_PRIMARY_MODE),
  .CFG_INITIAL_SOURCE(CFG_INITIAL_SOURCE), .CFG_SWITCH_MONITOR(CFG_SWITCH_MONITOR),
  .CFG_SECONDARY_POWER_VARIANT(CFG_SECONDARY_POWER_VARIANT), .CFG_SECONDARY_INPUT_TYPE(CFG_SECONDARY_INPUT_TYPE),
  .CFG_OUT_PIN_FUNCTION(CFG_OUT_PIN_FUNCTION), .PLL_ENABLE(PLL_ENABLE), .SECONDARY_HIGH_POWER(SECONDARY_HIGH_POWER),
  .MONITOR_ENABLED(MONITOR_ENABLED), .PROC_CLK_EN(PROC_CLK_EN), .INSTR_CLK_EN(INSTR_CLK_EN),
  .INSTR_CLK(INSTR_CLK), .OSC_OUT_O(OSC_OUT_O),
  .CURRENT_SOURCE(CURRENT_SOURCE), .OSC_OUT_OE(OSC_OUT_OE)
);

// [testbench/scs_osc_model.sv]
// Oscillator and clock input model making the source ticks
`timescale 1ns/100ps
module scs_osc_model (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Control
  input wire [5:0] stop,
  input wire pll_en,
  // Ticks
  output wire [5:0] tick,
  output wire pll_locked
);
  reg [4:0] cnt;
  reg [3:0] lcnt;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 5'h00;
      lcnt <= 4'h0;
    end else begin
      cnt <= cnt + 5'h01;
      lcnt <= !pll_en ? 4'h0 : lcnt + {3'h0, lcnt != 4'hf};
    end
  end
  // Stopped sources hold still
  assign tick[0] = !stop[0] && cnt[0];
  assign tick[1] = !stop[1] && &cnt[2:0];
  assign tick[2] = !stop[2] && &cnt[3:0];
  assign tick[3] = !stop[3] && &cnt;
  assign tick[4] = !stop[4] && &cnt[1:0];
  assign tick[5] = !stop[5] && pll_en;
  assign pll_locked = &lcnt;
endmodule

// [testbench/scs_top_test.sv]
// Self-checking bench for the clock source select block
`timescale 1ns/100ps
module scs_top_test;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wrs = 1'b0;
  reg rds = 1'b0;
  reg [1:0] pm = 2'h3;
  reg [2:0] src = 3'h7;
  reg [1:0] swm = 2'h3;
  reg typ = 1'b1;
  reg vr = 1'b0;
  reg ofn = 1'b1;
  reg [5:0] stop = 6'h00;
  reg [15:0] d;
  reg [2:0] c;
  reg p;
  integer i, n, cyc = 0, error_cnt = 0, num_checks = 0;
  wire [15:0] rdata;
  wire [5:0] tick, tune;
  wire [2:0] cur;
  wire [1:0] range, pmo;
  wire lk, pll_en, pll_pri, sec_en, hp, mon, pce, ice, oe;
  wire [1:0] en = {ice, pce};
  always #4 clk = ~clk;
  scs_osc_model osc (.clk(clk), .nrst(nrst), .stop(stop), .pll_en(pll_en), .tick(tick), .pll_locked(lk));
  scs_top uut (
    .CLK_SYS(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wrs), .REG_RD(rds),
    .REG_RDATA(rdata), .CFG_PRIMARY_MODE(pm), .CFG_INITIAL_SOURCE(src), .CFG_EXT_CLOCK_RANGE(pm),
    .CFG_SWITCH_MONITOR(swm), .CFG_SECONDARY_POWER_VARIANT(vr), .CFG_SECONDARY_INPUT_TYPE(typ),
    .CFG_OUT_PIN_FUNCTION(ofn), .FAST_RC_TICK(tick[0]), .SLOW_RC_TICK(tick[1]), .LOW_POWER_RC_TICK(tick[2]),
    .SECONDARY_OSC_TICK(tick[3]), .PRIMARY_OSC_TICK(tick[4]), .PLL_TICK(tick[5]), .PLL_LOCKED(lk),
    .PLL_ENABLE(pll_en), .PLL_FROM_PRIMARY(pll_pri), .SECONDARY_ENABLE(sec_en), .SECONDARY_HIGH_POWER(hp),
    .FAST_RC_TUNE(tune), .EXT_CLOCK_RANGE(range), .PRIMARY_MODE(pmo), .MONITOR_ENABLED(mon),
    .PROC_CLK_EN(pce), .INSTR_CLK(), .INSTR_CLK_EN(ice), .CURRENT_SOURCE(cur), .OSC_OUT_O(), .OSC_OUT_OE(oe)
  );
  // ------
  // Shared tasks
  // ------
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task boot(input [1:0] m, input [2:0] s, input [1:0] w, input t, input v);
    begin
      @(posedge clk);
      nrst <= 1'b0;
      pm <= m;
      src <= s;
      swm <= w;
      typ <= t;
      vr <= v;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(negedge clk);
    end
  endtask
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wrs <= 1'b1;
      @(posedge clk);
      wrs <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [15:0] v);
    begin
      @(posedge clk);
      addr <= a;
      rds <= 1'b1;
      @(posedge clk);
      rds <= 1'b0;
      @(negedge clk);
      v = rdata;
    end
  endtask
  task rc(input [15:0] m, input [15:0] e);
    begin
      rd(4'h0, d);
      chk("control", e, d & m);
    end
  endtask
  task wait_cur(input [2:0] s);
    begin
      n = 0;
      while (cur !== s && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task gap(input s, input [15:0] e);
    begin
      while (en[s] !== 1'b1) @(negedge clk);
      n = 1;
      @(negedge clk);
      while (en[s] !== 1'b1 && n < 99) begin
        @(negedge clk);
        n = n + 1;
      end
      chk("tick gap", e, n[15:0]);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ------
  // Scenarios
  // ------
  task t_erased;
    begin
      boot(2'h3, 3'h7, 2'h3, 1'b1, 1'b0);
      rc(16'hffff, 16'h7700);
      chk("range", 16'h0003, {14'h0000, range});
      chk("out enable", 16'h0001, {15'h0000, oe});
      wr(4'h0, 16'hffff);
      rc(16'hffff, 16'h7786);
      chk("high power", 16'h0001, {15'h0000, hp});
      wr(4'h0, 16'h0000);
      rc(16'hffff, 16'h7080);
      rd(4'h1, d);
      chk("divider", 16'h0001, d);
      wr(4'h2, 16'h002a);
      rd(4'h2, d);
      chk("tune", 16'h002a, d);
      chk("tune pins", 16'h002a, {10'h000, tune});
      rd(4'hf, d);
      chk("unmapped", 16'h0000, d);
      $display("erased settings test done");
    end
  endtask
  task t_switch;
    begin
      boot(2'h3, 3'h0, 2'h1, 1'b0, 1'b1);
      chk("power variant", 16'h0001, {15'h0000, hp});
      wr(4'h1, 16'h0003);
      for (i = 1; i < 9; i = i + 1) begin
        c = i[2:0];
        p = c == 3'h1 || c == 3'h3;
        wr(4'h0, {5'h00, c, 8'h01});
        rc(16'h0001, 16'h0001);
        wait_cur(c);
        rc(p ? 16'h7701 : 16'h7721, {1'b0, c, 1'b0, c, 8'h00});
        if (p) begin
          n = 0;
          d = 16'h0000;
          while (d[5] !== 1'b1 && n < 99) begin
            rd(4'h0, d);
            n = n + 1;
          end
          chk("lock", 16'h0020, d & 16'h0020);
          chk("multiplier", {14'h0000, c[1], 1'b1}, {14'h0000, pll_pri, pll_en});
        end
        if (c == 3'h4)
          chk("secondary on", 16'h0001, {15'h0000, sec_en});
        if (c == 3'h7) begin
          gap(1'b0, 16'h0010);
          gap(1'b1, 16'h0020);
        end
      end
      $display("switch test done");
    end
  endtask
  task t_fail;
    begin
      boot(2'h1, 3'h0, 2'h0, 1'b0, 1'b0);
      chk("monitor", 16'h0001, {15'h0000, mon});
      chk("primary mode", 16'h0001, {14'h0000, pmo});
      chk("out enable", 16'h0000, {15'h0000, oe});
      wr(4'h0, 16'h0501);
      wait_cur(3'h5);
      @(posedge clk);
      stop <= 6'h04;
      wait_cur(3'h0);
      rc(16'hffff, 16'h0508);
      @(posedge clk);
      stop <= 6'h00;
      wr(4'h0, 16'h0504);
      rc(16'hffff, 16'h0504);
      chk("high power", 16'h0000, {15'h0000, hp});
      wr(4'h0, 16'h0584);
      wr(4'h0, 16'h0301);
      rc(16'h7781, 16'h0580);
      $display("fail monitor test done");
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  initial begin
    t_erased;
    t_switch;
    t_fail;
    complete_run;
  end
endmodule
